// ==== src/uwt_dev.sv ====
`timescale 1ns/10ps
// Behaviour
// - data write loads transmit, read returns receive
// - receive shifter separate from read buffer
// - interrupt on done flags, software clears them
// - bit clocks: timer overflows divided by two
// - receive timer reloaded on start detection
// - software sets reload for twice bit rate
// - timer clock from six selectable sources
// - 8-bit frame: start, eight data, stop
// - 8-bit mode: stop bit into ninth flag
// - transmission starts on data write
// - transmit done set at stop bit start
// - reception only with receive enable set
// - 8-bit accept needs clear flag, filtered stop
// - overrun keeps first byte, drops later ones
// - 9-bit frame adds ninth data bit
// - transmitted ninth bit from control value
// - 9-bit mode: ninth bit stored, stop ignored
// - 9-bit accept needs clear flag, filtered ninth
// - master marks addresses with ninth bit one
// - slave software toggles filtering per message
// - control bit selects 8 or 9 bit
// - frame select zero 8-bit, resets zero
module uwt_dev
   import uwt_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   uwt_link_if.dev link,
   input wire logic serial_buffer_port_wr_i,
   input wire logic [7:0] serial_buffer_port_wdata_i,
   output logic [7:0] serial_buffer_port_rdata_o,
   input wire logic serial_control_reg_wr_i,
   input wire logic [7:0] serial_control_reg_wdata_i,
   output logic [7:0] serial_control_reg_rdata_o,
   input wire logic baud_timer_run_i,
   input wire logic [2:0] baud_timer_src_i,
   input wire logic [7:0] baud_timer_reload_i,
   input wire logic baud_ext_input_pin_i,
   input wire logic ext_osc_i,
   output logic irq_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rx_sync;
      logic rx_prev;
      logic [1:0] pin_sync;
      logic pin_prev;
      logic [1:0] osc_sync;
      logic osc_prev;
      logic [5:0] pre;
      logic [2:0] osc_div;
      logic [7:0] baud_timer_count;
      logic [7:0] rx_tmr;
      logic tx_half;
      logic rx_half;
      logic [7:0] ctl;
      logic [7:0] rx_buf;
      logic tx_pend;
      uwt_st_e tx_st;
      logic [3:0] tx_cnt;
      logic [8:0] tx_sh;
      logic txd;
      uwt_st_e rx_st;
      logic [3:0] rx_cnt;
      logic [7:0] rx_sh;
      logic rx_nb;
   } uwt_dev_s;

   uwt_dev_s s_q;
   uwt_dev_s s_d;

   // prescaler tap: true on the last clock of each group of n
   function automatic logic pre_tap(input logic [5:0] pre, input logic [5:0] n);
      logic [6:0] r;
      r = 7'({1'b0, pre} + 7'd1);
      pre_tap = (r % {1'b0, n}) == 7'd0;
   endfunction

   logic tick;
   logic tx_ov;
   logic rx_ov;
   logic tx_bit;
   logic rx_samp;
   logic rxs;
   logic nine;
   logic fbit;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      rxs = s_q.rx_sync[1];
      nine = s_q.ctl[CTL_MODE];
      fbit = 1'b0;

      // input synchronisers
      s_d.rx_sync = {s_q.rx_sync[0], link.rmt_txd};
      s_d.rx_prev = s_q.rx_sync[1];
      s_d.pin_sync = {s_q.pin_sync[0], baud_ext_input_pin_i};
      s_d.pin_prev = s_q.pin_sync[1];
      s_d.osc_sync = {s_q.osc_sync[0], ext_osc_i};
      s_d.osc_prev = s_q.osc_sync[1];

      // prescalers
      s_d.pre = (s_q.pre == PRE_LAST) ? '0 : 6'(s_q.pre + 6'd1);
      if (s_q.osc_sync[1] && !s_q.osc_prev) begin
         s_d.osc_div = 3'(s_q.osc_div + 3'd1);
      end

      unique case (uwt_src_e'(baud_timer_src_i))
         UWT_SRC_SYS: tick = 1'b1;
         UWT_SRC_DIV4: tick = pre_tap(s_q.pre, 6'd4);
         UWT_SRC_DIV12: tick = pre_tap(s_q.pre, 6'd12);
         UWT_SRC_DIV48: tick = pre_tap(s_q.pre, 6'd48);
         UWT_SRC_OSC8: tick = s_q.osc_sync[1] && !s_q.osc_prev && s_q.osc_div == OSC_DIV_LAST;
         UWT_SRC_PIN: tick = !s_q.pin_sync[1] && s_q.pin_prev;
         default: tick = 1'b0;
      endcase
      tick = tick && baud_timer_run_i;

      // transmit timer, auto reload, overflow halved
      tx_ov = tick && s_q.baud_timer_count == TMR_TOP;
      if (tick) begin
         s_d.baud_timer_count = tx_ov ? baud_timer_reload_i
                                      : 8'(s_q.baud_timer_count + 8'd1);
      end
      if (tx_ov) begin
         s_d.tx_half = !s_q.tx_half;
      end
      tx_bit = tx_ov && s_q.tx_half;

      rx_ov = tick && s_q.rx_tmr == TMR_TOP;
      if (tick) begin
         s_d.rx_tmr = rx_ov ? baud_timer_reload_i : 8'(s_q.rx_tmr + 8'd1);
      end
      if (rx_ov) begin
         s_d.rx_half = !s_q.rx_half;
      end
      rx_samp = rx_ov && !s_q.rx_half; // first overflow lands mid bit

      // software control register write, reserved bit fixed
      if (serial_control_reg_wr_i) begin
         s_d.ctl = serial_control_reg_wdata_i;
         s_d.ctl[CTL_RSVD] = CTL_RESET[CTL_RSVD];
      end

      // data write goes to transmit side only
      if (serial_buffer_port_wr_i && s_q.tx_st == UWT_IDLE && !s_q.tx_pend) begin
         s_d.tx_pend = 1'b1;
         // ninth bit taken from control value
         s_d.tx_sh = {s_d.ctl[CTL_TB8], serial_buffer_port_wdata_i};
      end

      // transmitter, steps on each bit clock
      if (tx_bit) begin
         unique case (s_q.tx_st)
            UWT_IDLE: begin
               if (s_q.tx_pend) begin
                  s_d.tx_pend = 1'b0;
                  s_d.txd = 1'b0;
                  s_d.tx_st = UWT_START;
               end
            end
            UWT_START: begin
               s_d.txd = s_q.tx_sh[0];
               s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
               s_d.tx_cnt = '0;
               s_d.tx_st = UWT_DATA;
            end
            UWT_DATA: begin
               if (s_q.tx_cnt == DATA_LAST) begin
                  // ninth bit sent in 9-bit mode
                  if (nine) begin
                     s_d.txd = s_q.tx_sh[0];
                     s_d.tx_st = UWT_NINTH;
                  end else begin
                     // done flag at stop bit start
                     s_d.txd = 1'b1;
                     s_d.ctl[CTL_TI] = 1'b1;
                     s_d.tx_st = UWT_STOP;
                  end
               end else begin
                  s_d.txd = s_q.tx_sh[0];
                  s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
                  s_d.tx_cnt = 4'(s_q.tx_cnt + 4'd1);
               end
            end
            UWT_NINTH: begin
               // done flag at stop bit start
               s_d.txd = 1'b1;
               s_d.ctl[CTL_TI] = 1'b1;
               s_d.tx_st = UWT_STOP;
            end
            UWT_STOP: s_d.tx_st = UWT_IDLE;
            default: s_d.tx_st = UWT_IDLE;
         endcase
      end

      // start detection only with receive enable
      if (s_q.rx_st == UWT_IDLE) begin
         if (s_q.ctl[CTL_REN] && s_q.rx_prev && !rxs) begin
            s_d.rx_tmr = baud_timer_reload_i;
            s_d.rx_half = 1'b0;
            s_d.rx_st = UWT_START;
         end
      end else if (rx_samp) begin
         // shifting continues while buffer holds a byte
         unique case (s_q.rx_st)
            UWT_START: begin
               s_d.rx_cnt = '0;
               s_d.rx_st = rxs ? UWT_IDLE : UWT_DATA; // glitch rejected
            end
            UWT_DATA: begin
               s_d.rx_sh = {rxs, s_q.rx_sh[7:1]};
               s_d.rx_cnt = 4'(s_q.rx_cnt + 4'd1);
               if (s_q.rx_cnt == DATA_LAST) begin
                  s_d.rx_st = nine ? UWT_NINTH : UWT_STOP;
               end
            end
            UWT_NINTH: begin
               s_d.rx_nb = rxs;
               s_d.rx_st = UWT_STOP;
            end
            UWT_STOP: begin
               fbit = nine ? s_q.rx_nb : rxs;
               if (!s_d.ctl[CTL_RI] && (!s_d.ctl[CTL_MCE] || fbit)) begin
                  s_d.rx_buf = s_q.rx_sh;
                  s_d.ctl[CTL_RB8] = fbit;
                  s_d.ctl[CTL_RI] = 1'b1;
               end
               s_d.rx_st = UWT_IDLE;
            end
            default: s_d.rx_st = UWT_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // reset values
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '{rx_sync: 2'b11, rx_prev: 1'b1, pin_sync: 2'b00, pin_prev: 1'b0,
                  osc_sync: 2'b00, osc_prev: 1'b0, pre: 6'h00, osc_div: 3'h0,
                  baud_timer_count: TMR_RESET, rx_tmr: TMR_RESET, tx_half: 1'b0,
                  rx_half: 1'b0, ctl: CTL_RESET, rx_buf: 8'h00, tx_pend: 1'b0,
                  tx_st: UWT_IDLE, tx_cnt: 4'h0, tx_sh: 9'h000, txd: 1'b1,
                  rx_st: UWT_IDLE, rx_cnt: 4'h0, rx_sh: 8'h00, rx_nb: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // reads return only the receive buffer
   assign serial_buffer_port_rdata_o = s_q.rx_buf;
   assign serial_control_reg_rdata_o = s_q.ctl;
   assign link.dev_txd = s_q.txd;
   // interrupt while either done flag stands
   assign irq_o = s_q.ctl[CTL_TI] || s_q.ctl[CTL_RI];
endmodule

// ==== src/uwt_link_if.sv ====
`timescale 1ns/10ps
// serial line pair between the device and the remote end
interface uwt_link_if;
   logic dev_txd; // device transmit, remote receive
   logic rmt_txd; // remote transmit, device receive
   modport dev (output dev_txd, input rmt_txd);
   modport rmt (input dev_txd, output rmt_txd);
endinterface

// ==== src/uwt_pkg.sv ====
package uwt_pkg;
   // ---------------------------------------------------------------
   // control register field positions and reset value
   // ---------------------------------------------------------------
   localparam int CTL_MODE = 7; // frame_length_select
   localparam int CTL_RSVD = 6; // reads back as one
   localparam int CTL_MCE = 5; // addr_filter_enable
   localparam int CTL_REN = 4; // receive enable
   localparam int CTL_TB8 = 3; // tx_ninth_bit
   localparam int CTL_RB8 = 2; // rx_ninth_bit
   localparam int CTL_TI = 1; // tx_done_flag
   localparam int CTL_RI = 0; // rx_done_flag
   localparam logic [7:0] CTL_RESET = 8'h40;

   // ---------------------------------------------------------------
   // baud timer
   // ---------------------------------------------------------------
   localparam logic [7:0] TMR_TOP = 8'hff;
   localparam logic [7:0] TMR_RESET = 8'h00;
   localparam logic [5:0] PRE_LAST = 6'h2f; // prescaler wraps every 48 clocks
   localparam logic [2:0] OSC_DIV_LAST = 3'h7; // external oscillator / 8
   localparam logic [3:0] DATA_LAST = 4'h7; // eight data bits

   typedef enum logic [2:0] {
      UWT_SRC_SYS = 3'b000,
      UWT_SRC_DIV4 = 3'b001,
      UWT_SRC_DIV12 = 3'b010,
      UWT_SRC_DIV48 = 3'b011,
      UWT_SRC_OSC8 = 3'b100,
      UWT_SRC_PIN = 3'b101
   } uwt_src_e;

   // serial engine states
   typedef enum logic [2:0] {
      UWT_IDLE = 3'b000,
      UWT_START = 3'b001,
      UWT_DATA = 3'b010,
      UWT_NINTH = 3'b011,
      UWT_STOP = 3'b100
   } uwt_st_e;

   // remote end default bit period in clocks
   localparam int RMT_BIT_CLKS = 64;
endpackage

// ==== src/uwt_rmt.sv ====
`timescale 1ns/10ps
// remote transceiver on the multidrop line, fixed bit period
module uwt_rmt
   import uwt_pkg::*;
#(
   parameter int BIT_CLKS = RMT_BIT_CLKS
)(
   input wire logic clk_i,
   input wire logic resetn_i,
   uwt_link_if.rmt link,
   input wire logic nine_bit_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_ninth_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic rx_ninth_o,
   output logic rx_stop_o
);
   localparam logic [15:0] BIT_LAST = 16'(BIT_CLKS - 1);
   localparam logic [15:0] HALF_LAST = 16'(BIT_CLKS / 2 - 1);

   typedef struct packed {
      logic [1:0] rx_sync;
      logic rx_prev;
      logic tx_busy;
      logic [3:0] tx_left;
      logic [10:0] tx_sh;
      logic [15:0] tx_tmr;
      logic txd;
      logic rx_busy;
      logic [3:0] rx_cnt;
      logic [10:0] rx_sh;
      logic [15:0] rx_tmr;
      logic rx_valid;
      logic [7:0] rx_data;
      logic rx_ninth;
      logic rx_stop;
   } uwt_rmt_s;

   uwt_rmt_s s_q;
   uwt_rmt_s s_d;
   logic rxs;
   logic [3:0] nbits;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      rxs = s_q.rx_sync[1];
      nbits = nine_bit_i ? 4'd11 : 4'd10;
      s_d.rx_sync = {s_q.rx_sync[0], link.dev_txd};
      s_d.rx_prev = s_q.rx_sync[1];
      s_d.rx_valid = 1'b0;

      if (!s_q.tx_busy) begin
         if (tx_valid_i) begin
            s_d.tx_busy = 1'b1;
            s_d.tx_left = nbits;
            s_d.tx_tmr = '0;
            s_d.tx_sh = nine_bit_i ? {1'b1, tx_ninth_i, tx_data_i, 1'b0}
                                   : {2'b11, tx_data_i, 1'b0};
         end
      end else if (s_q.tx_tmr == '0) begin
         if (s_q.tx_left == '0) begin
            s_d.tx_busy = 1'b0;
         end else begin
            s_d.txd = s_q.tx_sh[0];
            s_d.tx_sh = {1'b1, s_q.tx_sh[10:1]};
            s_d.tx_left = 4'(s_q.tx_left - 4'd1);
            s_d.tx_tmr = BIT_LAST;
         end
      end else begin
         s_d.tx_tmr = 16'(s_q.tx_tmr - 16'd1);
      end

      // receiver samples mid bit
      if (!s_q.rx_busy) begin
         if (s_q.rx_prev && !rxs) begin
            s_d.rx_busy = 1'b1;
            s_d.rx_cnt = '0;
            s_d.rx_tmr = HALF_LAST;
         end
      end else if (s_q.rx_tmr != '0) begin
         s_d.rx_tmr = 16'(s_q.rx_tmr - 16'd1);
      end else begin
         s_d.rx_sh[s_q.rx_cnt] = rxs;
         s_d.rx_cnt = 4'(s_q.rx_cnt + 4'd1);
         s_d.rx_tmr = BIT_LAST;
         if (s_q.rx_cnt == 4'd0 && rxs) begin
            s_d.rx_busy = 1'b0; // false start
         end else if (4'(s_q.rx_cnt + 4'd1) == nbits) begin
            s_d.rx_busy = 1'b0;
            s_d.rx_valid = 1'b1;
            s_d.rx_data = s_d.rx_sh[8:1];
            s_d.rx_ninth = nine_bit_i ? s_d.rx_sh[9] : 1'b0;
            s_d.rx_stop = nine_bit_i ? s_d.rx_sh[10] : s_d.rx_sh[9];
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '{rx_sync: 2'b11, rx_prev: 1'b1, tx_busy: 1'b0, tx_left: 4'h0,
                  tx_sh: 11'h7ff, tx_tmr: 16'h0000, txd: 1'b1, rx_busy: 1'b0,
                  rx_cnt: 4'h0, rx_sh: 11'h000, rx_tmr: 16'h0000, rx_valid: 1'b0,
                  rx_data: 8'h00, rx_ninth: 1'b0, rx_stop: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign link.rmt_txd = s_q.txd;
   assign tx_ready_o = !s_q.tx_busy;
   assign rx_valid_o = s_q.rx_valid;
   assign rx_data_o = s_q.rx_data;
   assign rx_ninth_o = s_q.rx_ninth;
   assign rx_stop_o = s_q.rx_stop;
endmodule

// ==== test/uart_with_timer_baud_gen_test.sv ====
`timescale 1ns/10ps
module uart_with_timer_baud_gen_test
   import uwt_pkg::*;
;
   localparam int BITC = 32;
   localparam int TMO = 1000;
   logic clk_i, resetn_i, buf_wr, ctl_wr, tmr_run, ext_pin, ext_osc;
   logic [7:0] buf_wdata, ctl_wdata, tmr_reload, dev_rdata, ctl_rdata;
   logic [2:0] tmr_src;
   logic irq, nine_bit, rtx_valid, rtx_ninth, rtx_ready, rrx_valid, rrx_ninth, rrx_stop;
   logic [7:0] rtx_data, rrx_data;
   int num_errors = 0;
   int cmp_count = 0;

   uwt_link_if link ();
   uwt_dev i_uwt_dev (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
      .serial_buffer_port_wr_i(buf_wr), .serial_buffer_port_wdata_i(buf_wdata),
      .serial_buffer_port_rdata_o(dev_rdata), .serial_control_reg_wr_i(ctl_wr),
      .serial_control_reg_wdata_i(ctl_wdata), .serial_control_reg_rdata_o(ctl_rdata),
      .baud_timer_run_i(tmr_run), .baud_timer_src_i(tmr_src),
      .baud_timer_reload_i(tmr_reload), .baud_ext_input_pin_i(ext_pin),
      .ext_osc_i(ext_osc), .irq_o(irq));
   uwt_rmt #(.BIT_CLKS(BITC)) i_uwt_rmt (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
      .nine_bit_i(nine_bit), .tx_valid_i(rtx_valid), .tx_data_i(rtx_data),
      .tx_ninth_i(rtx_ninth), .tx_ready_o(rtx_ready), .rx_valid_o(rrx_valid),
      .rx_data_o(rrx_data), .rx_ninth_o(rrx_ninth), .rx_stop_o(rrx_stop));
   uwt_link_props #(.BIT_CLKS(BITC)) i_uwt_link_props (.clk_i(clk_i), .resetn_i(resetn_i),
      .dev_txd(link.dev_txd), .rmt_txd(link.rmt_txd));

   // clock at 40 MHz
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tmo_chk(input int n);
      if (n >= TMO) begin
         chk(8'h01, 8'h00);
         stop_test;
      end
   endtask
   task automatic ctl_w(input logic [7:0] v);
      @(posedge clk_i);
      ctl_wr <= 1'b1;
      ctl_wdata <= v;
      @(posedge clk_i);
      ctl_wr <= 1'b0;
   endtask
   task automatic buf_w(input logic [7:0] v);
      @(posedge clk_i);
      buf_wr <= 1'b1;
      buf_wdata <= v;
      @(posedge clk_i);
      buf_wr <= 1'b0;
   endtask
   // bounded wait for a control flag, returns cycles waited
   task automatic wait_bit(input int b, output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ctl_rdata[b] !== 1'b1 && n < TMO);
      tmo_chk(n);
   endtask
   task automatic wait_rrx(output int n);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (rrx_valid !== 1'b1 && n < TMO);
      tmo_chk(n);
   endtask
   // remote idle plus one bit of margin for the device stop sample
   task automatic rmt_idle;
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (rtx_ready !== 1'b1 && n < TMO);
      tmo_chk(n);
      repeat (BITC) @(negedge clk_i);
   endtask
   task automatic rmt_tx(input logic [7:0] d, input logic b9);
      rmt_idle;
      @(posedge clk_i);
      rtx_valid <= 1'b1;
      rtx_data <= d;
      rtx_ninth <= b9;
      @(posedge clk_i);
      rtx_valid <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic s_reset;
      @(negedge clk_i);
      chk(CTL_RESET, ctl_rdata);
      chk(8'h00, {dev_rdata[7:1], irq});
      chk(8'h01, {7'h00, link.dev_txd});
   endtask
   // 8-bit transmit from two timer sources, done flag at stop start
   task automatic s_tx8;
      int n;
      for (int i = 0; i < 2; i++) begin
         repeat (BITC) @(posedge clk_i);
         tmr_src <= i ? UWT_SRC_DIV4 : UWT_SRC_SYS;
         tmr_reload <= i ? 8'hfc : 8'hf0;
         nine_bit <= 1'b0;
         ctl_w(8'h00);
         buf_w(8'ha5 ^ i[7:0]);
         wait_bit(CTL_TI, n);
         wait_rrx(n);
         chk(8'h01, {7'h00, n <= BITC});
         chk(8'ha5 ^ i[7:0], rrx_data);
         chk(8'h03, {rrx_stop, irq});
         chk(8'h00, dev_rdata);
         ctl_w(8'h00);
         @(negedge clk_i);
         chk(8'h00, {7'h00, irq});
      end
   endtask
   // 9-bit transmit with both ninth bit values
   task automatic s_tx9;
      int n;
      for (int j = 0; j < 2; j++) begin
         repeat (BITC) @(posedge clk_i);
         nine_bit <= 1'b1;
         ctl_w(j ? 8'h88 : 8'h80);
         buf_w(8'h3c);
         wait_rrx(n);
         chk(8'h3c, rrx_data);
         chk({7'h00, j[0]}, {7'h00, rrx_ninth});
      end
      ctl_w(8'h00);
   endtask
   // 8-bit receive: enable, buffering, overrun
   task automatic s_rx8;
      int n;
      @(posedge clk_i);
      nine_bit <= 1'b0;
      rmt_tx(8'h5a, 1'b0);
      rmt_idle;
      chk(8'h00, {dev_rdata[7:1], ctl_rdata[CTL_RI]});
      ctl_w(8'h10);
      rmt_tx(8'h5a, 1'b0);
      wait_bit(CTL_RI, n);
      chk(8'h5a, dev_rdata);
      chk(8'h01, {7'h00, ctl_rdata[CTL_RB8]});
      rmt_tx(8'hc3, 1'b0);
      repeat (4 * BITC) @(posedge clk_i);
      ctl_w(8'h10);
      chk(8'h5a, dev_rdata);
      wait_bit(CTL_RI, n);
      chk(8'hc3, dev_rdata);
      rmt_tx(8'h99, 1'b0);
      rmt_idle;
      chk(8'hc3, dev_rdata);
   endtask
   // 9-bit receive with address filtering
   task automatic s_rx9;
      int n;
      ctl_w(8'hb0);
      @(posedge clk_i);
      nine_bit <= 1'b1;
      rmt_tx(8'h11, 1'b0);
      rmt_idle;
      chk(8'h00, {7'h00, ctl_rdata[CTL_RI]});
      rmt_tx(8'h22, 1'b1);
      wait_bit(CTL_RI, n);
      chk(8'h22, dev_rdata);
      chk(8'h01, {7'h00, ctl_rdata[CTL_RB8]});
      ctl_w(8'h94);
      rmt_tx(8'h33, 1'b0);
      wait_bit(CTL_RI, n);
      chk(8'h33, dev_rdata);
      chk(8'h00, {7'h00, ctl_rdata[CTL_RB8]});
   endtask
   // remaining timer sources, cycles from data write to done flag
   task automatic s_src;
      int n;
      int bit_clks;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         tmr_src <= 3'(k + 2);
         tmr_reload <= (k == 3) ? 8'hf8 : ((k == 0) ? 8'hfc : 8'hff);
         bit_clks = (k < 2) ? 3 * BITC : BITC;
         repeat (8 * BITC) @(posedge clk_i);
         ctl_w(8'h00);
         buf_w(8'hff);
         wait_bit(CTL_TI, n);
         chk(8'h01, {7'h00, n > 9 * bit_clks && n <= 10 * bit_clks});
      end
   endtask

   // free running external clock and pin, one edge per clock
   initial begin
      ext_pin = 1'b0;
      ext_osc = 1'b0;
      forever begin
         @(posedge clk_i);
         ext_pin <= ~ext_pin;
         ext_osc <= ~ext_osc;
      end
   end

   // reset, then the scenarios in turn
   initial begin
      resetn_i = 1'b0;
      {buf_wr, ctl_wr, tmr_run, nine_bit, rtx_valid, rtx_ninth} = 6'h00;
      {buf_wdata, ctl_wdata, rtx_data} = 24'h00_0000;
      tmr_src = UWT_SRC_SYS;
      tmr_reload = 8'hf0;
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      tmr_run <= 1'b1;
      s_reset;
      s_tx8;
      s_tx9;
      s_rx8;
      s_rx9;
      s_src;
      stop_test;
   end
endmodule

// ==== test/uwt_link_props.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------
// serial line checks between the two ends
// ---------------------------------------------------------------
module uwt_link_props
   import uwt_pkg::*;
#(
   parameter int BIT_CLKS = RMT_BIT_CLKS
)(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic dev_txd,
   input wire logic rmt_txd
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   logic [9:0] dev_lo_q;
   logic [9:0] dev_hi_q;
   logic [9:0] rmt_lo_q;
   logic [9:0] rmt_hi_q;

   // run lengths of low and high levels, high saturates
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dev_lo_q <= 10'h000;
         rmt_lo_q <= 10'h000;
         dev_hi_q <= 10'h3ff;
         rmt_hi_q <= 10'h3ff;
      end else begin
         dev_lo_q <= dev_txd ? 10'h000 : dev_lo_q + 10'h001;
         rmt_lo_q <= rmt_txd ? 10'h000 : rmt_lo_q + 10'h001;
         dev_hi_q <= !dev_txd ? 10'h000 : dev_hi_q + {9'h000, dev_hi_q != 10'h3ff};
         rmt_hi_q <= !rmt_txd ? 10'h000 : rmt_hi_q + {9'h000, rmt_hi_q != 10'h3ff};
      end
   end

   // line idle high when reset ends
   property p_dev_idle_rst;
      $rose(resetn_i) |-> dev_txd;
   endproperty
   a_dev_idle_rst: assert property (p_dev_idle_rst) else $error("device line low after reset");
   property p_rmt_idle_rst;
      $rose(resetn_i) |-> rmt_txd;
   endproperty
   a_rmt_idle_rst: assert property (p_rmt_idle_rst) else $error("remote line low after reset");
   // low runs are whole bits, at most start plus nine zeros
   property p_dev_low_run;
      $rose(dev_txd) |-> (dev_lo_q % BIT_CLKS == 0) && (dev_lo_q <= 10 * BIT_CLKS);
   endproperty
   a_dev_low_run: assert property (p_dev_low_run) else $error("device low run not whole bits");
   property p_rmt_low_run;
      $rose(rmt_txd) |-> (rmt_lo_q % BIT_CLKS == 0) && (rmt_lo_q <= 10 * BIT_CLKS);
   endproperty
   a_rmt_low_run: assert property (p_rmt_low_run) else $error("remote low run not whole bits");
   // a high level lasts at least one bit before a fall
   property p_dev_high_min;
      $fell(dev_txd) |-> dev_hi_q >= BIT_CLKS;
   endproperty
   a_dev_high_min: assert property (p_dev_high_min) else $error("device high run too short");
   property p_rmt_high_min;
      $fell(rmt_txd) |-> rmt_hi_q >= BIT_CLKS;
   endproperty
   a_rmt_high_min: assert property (p_rmt_high_min) else $error("remote high run too short");
   // start bit holds low for its first clocks
   property p_dev_start;
      $fell(dev_txd) |-> !dev_txd [*8];
   endproperty
   a_dev_start: assert property (p_dev_start) else $error("device start bit too short");
   property p_rmt_start;
      $fell(rmt_txd) |-> !rmt_txd [*8];
   endproperty
   a_rmt_start: assert property (p_rmt_start) else $error("remote start bit too short");

   c_dev_frame: cover property ($fell(dev_txd));
   c_rmt_frame: cover property ($fell(rmt_txd));
   c_dev_long_low: cover property ($rose(dev_txd) && dev_lo_q > BIT_CLKS);
endmodule
